/* File: bench/nmc_csr_bank_sva.sv */
// Checker of the register bank's port behaviour.
`timescale 1ns/10ps
`default_nettype none
module nmc_csr_bank_sva (
    input wire logic                 clk_i,
    input wire logic                 rst_i,
    input wire nmc_pkg::nmc_bus_type bus_i,
    input wire logic [31:0]          rdata_o,
    input wire logic [31:0]          tx_desc_ptr_i,
    input wire logic [31:0]          rx_desc_ptr_i,
    input wire logic                 four_led_mode_i,
    input wire logic                 fd_col_led_i,
    input wire nmc_pkg::nmc_rom_type rom_o,
    input wire logic                 shared_pin_o
);
    import nmc_pkg::*;
    // ==========================================================
    // One clock domain, so clocking and reset are given once.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_rdata_idle_zero:
        assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("read data not zero when idle");
    chk_tx_ptr_read:
        assert property ($past(bus_i.rd) && $past(bus_i.addr) == nmc_off_tx_desc |-> rdata_o == $past(tx_desc_ptr_i, 2))
        else $error("tx pointer read wrong");
    chk_rx_ptr_read:
        assert property ($past(bus_i.rd) && $past(bus_i.addr) == nmc_off_rx_desc |-> rdata_o == $past(rx_desc_ptr_i, 2))
        else $error("rx pointer read wrong");
    chk_led_pin_mux:
        assert property (!$past(rst_i) && !$past(four_led_mode_i) |-> shared_pin_o == $past(fd_col_led_i))
        else $error("shared pin not the led outside four-led mode");
    chk_rd_strobe_len:
        assert property ($fell(rom_o.rd_n) |-> !rom_o.rd_n [*4] ##1 rom_o.rd_n) else $error("read strobe length");
    chk_wr_strobe_len:
        assert property ($fell(rom_o.wr_n) |-> (rom_o.data_oe && !rom_o.wr_n) [*3] ##1 rom_o.wr_n)
        else $error("write strobe length or data enable");
    chk_rd_excl:
        assert property (!rom_o.rd_n |-> rom_o.wr_n && !rom_o.data_oe) else $error("read overlaps write drive");
    chk_rd_addr_hold:
        assert property (!rom_o.rd_n && !$fell(rom_o.rd_n) |-> $stable(rom_o.addr)) else $error("address moved in read");
    chk_wr_data_hold:
        assert property (!rom_o.wr_n && !$fell(rom_o.wr_n) |-> $stable(rom_o.dout) && $stable(rom_o.addr))
        else $error("address or data moved in write");
endmodule
bind nmc_csr_bank nmc_csr_bank_sva i_sva (.clk_i, .rst_i, .bus_i, .rdata_o, .tx_desc_ptr_i, .rx_desc_ptr_i,
    .four_led_mode_i, .fd_col_led_i, .rom_o, .shared_pin_o);
`default_nettype wire

/* File: bench/nmc_rom_model.sv */
// Behavioural external flash ROM facing the bank's flash port.
`timescale 1ns/10ps
`default_nettype none
module nmc_rom_model (
    input  wire logic                 clk_i,
    input  wire nmc_pkg::nmc_rom_type rom_i,
    output logic [7:0]                rom_din_o
);
    import nmc_pkg::*;
    // ==========================================================
    // Storage
    // Only the low address byte picks a cell, so the model stays small.
    logic [7:0] mem [256];
    logic [7:0] last;   // Last byte shown on the data lines.
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hC3;
        end
        last = 8'h00;
    end
    // address and data
    // A write lands while the strobe is low and the bank drives the data lines.
    always @(posedge clk_i) begin
        if (!rom_i.wr_n && rom_i.data_oe) begin
            mem[rom_i.addr[7:0]] <= rom_i.dout;
        end
        if (!rom_i.rd_n) begin
            last <= mem[rom_i.addr[7:0]];
        end
    end
    // address and data
    // Released lines show the inverse of the last byte, so a late sample is caught.
    assign rom_din_o = !rom_i.rd_n ? mem[rom_i.addr[7:0]] : ~last;
endmodule
`default_nettype wire

/* File: bench/test_nmc_csr_bank.sv */
// Self-checking testbench of the register bank.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %h want %h", $time, g, e); end end
module test_nmc_csr_bank;
    import nmc_pkg::*;
    // ==========================================================
    // Stimulus and observed signals.
    logic clk_i = 1'b0, rst_i = 1'b1, tx_ok = 1'b0, tx_start = 1'b0, dload = 1'b0, tx_deferred_irq_enable = 1'b0;
    logic spd = 1'b1, fled = 1'b0, fdcol = 1'b0, eload = 1'b0, pin, irq;
    logic [31:0] txp = 32'h0, rxp = 32'h0, eval = 32'h0, rdata, v, w;
    logic [11:0] dbo = 12'h0;
    logic [7:0] din, d;
    logic [17:0] a;
    nmc_bus_type bus = '0;
    nmc_rom_type rom;
    int seed, failures = 0, check_count = 0;
    always #20 clk_i = ~clk_i;
    nmc_csr_bank i_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .tx_desc_ptr_i(txp),
        .rx_desc_ptr_i(rxp), .tx_ok_i(tx_ok), .tx_start_i(tx_start), .defer_backoff_i(dbo), .defer_load_i(dload),
        .tx_deferred_irq_enable_i(tx_deferred_irq_enable), .speed_100_i(spd), .four_led_mode_i(fled), .fd_col_led_i(fdcol),
        .eeprom_load_i(eload), .eeprom_sta_low_i(eval), .rom_din_i(din), .rom_o(rom), .shared_pin_o(pin),
        .irq_o(irq));
    nmc_rom_model i_rom (.clk_i(clk_i), .rom_i(rom), .rom_din_o(din));
    // ==========================================================
    // Bus cycles: strobes last one cycle, read data sampled in the next one.
    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        @(posedge clk_i);
        bus <= '{addr: ad, wdata: dt, wr: 1'b1, rd: 1'b0};
        @(posedge clk_i);
        bus <= '0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
        @(posedge clk_i);
        bus <= '{addr: ad, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_i);
        bus <= '0;
        #1 dt = rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one access
    // Poll the enable bit under a bound before any further flash access.
    task automatic poll(input int b);
        int n;
        n = 0;
        v = 32'hFFFFFFFF;
        while (v[b] !== 1'b0 && n < 40) begin
            rd(nmc_off_rom, v);
            n++;
        end
        if (n == 40) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A hung wait anywhere still reaches the verdict.
    initial begin
        #2400000;
        failures++;
        wrap_up();
    end
    initial begin
        seed = 71;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(nmc_off_rom, v); `CHK(v, nmc_rom_reset)
        rd(nmc_off_burst, v); `CHK(v, nmc_burst_reset)
        rd(8'h50, v); `CHK(v, 32'h0)
        for (int k = 0; k < 4; k++) begin
            txp <= $random(seed);
            rxp <= $random(seed);
            wr(nmc_off_tx_desc, 32'hFFFFFFFF);
            rd(nmc_off_tx_desc, v); `CHK(v, txp)
            rd(nmc_off_rx_desc, v); `CHK(v, rxp)
        end
        $display("end of pointer test");
        eval <= $random(seed);
        eload <= 1'b1;
        cyc(1);
        eload <= 1'b0;
        rd(nmc_off_sta_low, v); `CHK(v, eval)
        // stopped receive: no receive engine runs here, so station writes are legal.
        w = $random(seed);
        wr(nmc_off_sta_low, w);
        rd(nmc_off_sta_low, v); `CHK(v, w)
        for (int k = 0; k < 4; k++) begin
            a = {10'($random(seed)), 8'(k)};
            d = 8'($random(seed));
            wr(nmc_off_rom, (32'h1 << nmc_wen_bit) | {6'h0, a, d});
            poll(nmc_wen_bit);
            wr(nmc_off_rom, (32'h1 << nmc_ren_bit) | {6'h0, a, 8'h00});
            poll(nmc_ren_bit);
            `CHK(v[7:0], d)
            `CHK(v[25:8], a)
            a[7:0] = 8'h80 | 8'(k);
            wr(nmc_off_rom, (32'h1 << nmc_ren_bit) | {6'h0, a, 8'h00});
            poll(nmc_ren_bit);
            `CHK(v[7:0], a[7:0] ^ 8'hC3)
        end
        $display("end of flash test");
        fled <= 1'b1;
        wr(nmc_off_rom, 32'h80000000 | {6'h0, 18'h20000, 8'h00});
        cyc(3); `CHK(pin, 1'b1)
        fdcol <= 1'b1;
        wr(nmc_off_rom, {6'h0, 18'h20000, 8'h00});
        cyc(3); `CHK(pin, 1'b1)
        fdcol <= 1'b0;
        cyc(3); `CHK(pin, 1'b0)
        wr(nmc_off_rom, 32'h80000000 | {6'h0, 18'h20000, 8'h00});
        fled <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            fdcol <= 1'($random(seed));
            cyc(3); `CHK(pin, fdcol)
        end
        $display("end of pin test");
        // Burst count three, checked twice so the restart is seen.
        wr(nmc_off_irq_mask, 32'h1);
        wr(nmc_off_burst, 32'h3 << nmc_burst_lsb);
        for (int r = 0; r < 2; r++) begin
            for (int p = 0; p < 3; p++) begin
                cyc(4); `CHK(irq, 1'b0)
                tx_ok <= 1'b1;
                cyc(1);
                tx_ok <= 1'b0;
            end
            cyc(4); `CHK(irq, 1'b1)
            rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_done_bit], 1'b1)
            wr(nmc_off_irq_stat, 32'h1);
            cyc(3); `CHK(irq, 1'b0)
        end
        $display("end of burst test");
        // Deferral timer, masked out so the level stays low.
        dbo <= 12'hABC;
        dload <= 1'b1;
        cyc(1);
        dload <= 1'b0;
        cyc(100);
        rd(nmc_off_burst, v); `CHK(v[11:0], 12'hABC)
        dbo <= 12'h002;
        dload <= 1'b1;
        cyc(1);
        dload <= 1'b0;
        cyc(200);
        rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_def_bit], 1'b0)
        tx_deferred_irq_enable <= 1'b1;
        cyc(200);
        rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_def_bit], 1'b1)
        `CHK(irq, 1'b0)
        wr(nmc_off_irq_stat, 32'h2);
        dload <= 1'b1;
        cyc(1);
        dload <= 1'b0;
        cyc(5);
        tx_start <= 1'b1;
        cyc(1);
        tx_start <= 1'b0;
        cyc(300);
        rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_def_bit], 1'b0)
        spd <= 1'b0;
        dload <= 1'b1;
        cyc(1);
        dload <= 1'b0;
        cyc(300);
        rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_def_bit], 1'b0)
        cyc(1100);
        rd(nmc_off_irq_stat, v); `CHK(v[nmc_irq_def_bit], 1'b1)
        $display("end of timer test");
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: rtl/nmc_csr_bank.sv */
// NIC miscellaneous control and status register bank with flash port.
// ==========================================================
// ==========================================================
// Overview
// Host reads two pointer copies, a burst
// and time-out word, the flash port, the
// station address bytes 0 to 3 and two interrupt words.
// The flash sequencer owns the ROM pins
// for four cycles per access and frees
// its enable bit when done.
// Limitation: a second flash command sent
// while one is busy is dropped, not queued.
// Interrupt events are sticky and
// cleared by writing a one; a mask of
// the same layout gates one level line.
// The pointers are plain copies of
// same-clock DMA state, not synchronised.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module nmc_csr_bank (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire nmc_pkg::nmc_bus_type bus_i,
    output logic [31:0]               rdata_o,
    input  wire logic [31:0]          tx_desc_ptr_i,
    input  wire logic [31:0]          rx_desc_ptr_i,
    input  wire logic                 tx_ok_i,
    input  wire logic                 tx_start_i,
    input  wire logic [11:0]          defer_backoff_i,
    input  wire logic                 defer_load_i,
    input  wire logic                 tx_deferred_irq_enable_i,
    input  wire logic                 speed_100_i,
    input  wire logic                 four_led_mode_i,
    input  wire logic                 fd_col_led_i,
    input  wire logic                 eeprom_load_i,
    input  wire logic [31:0]          eeprom_sta_low_i,
    input  wire logic [7:0]           rom_din_i,
    output nmc_pkg::nmc_rom_type      rom_o,
    output logic                      shared_pin_o,
    output logic                      irq_o
);
    import nmc_pkg::*;
    // No wait states: writes land at the
    // strobe edge, reads answer next cycle.

    // ==========================================================
    // Storage.
    logic [31:0]       tx_desc;          // Sampled working tx pointer.
    logic [31:0]       rx_desc;          // Sampled working rx pointer.
    logic [4:0]        tx_burst_count;   // Programmed burst length.
    logic [4:0]        burst_done;       // Successful sends since last event.
    logic [11:0]       tx_timeout_timer; // Deferral timer.
    logic              timer_armed;      // Timer holds a live count.
    logic [10:0]       tick_cnt;         // Divider for the timer tick.
    logic              tick;             // One-cycle timer tick.
    logic              rom_addr16_enable; // Address-16 request bit.
    logic              rd_en;            // Read enable bit.
    logic              wr_en;            // Write enable bit.
    logic [17:0]       rom_addr;         // Flash address field.
    logic [7:0]        rom_data;         // Flash data field.
    nmc_rom_state_type rom_state;        // Flash sequencer state.
    logic [2:0]        rom_cnt;          // Strobe length counter.
    logic [31:0]       sta_low;          // Station address bytes 0 to 3.
    logic [1:0]        irq_stat;         // Sticky event bits.
    logic [1:0]        irq_mask;         // Interrupt enables.
    logic              ev_done;          // Burst reached this cycle.
    logic              ev_def;           // Timer expired this cycle.
    logic [31:0]       rom_word;         // Flash port as software reads it.
    logic              wr_rom;           // Write strobe aimed at the port.
    logic [7:0]        rom_din_meta;     // First stage; read by the second only.
    logic [7:0]        rom_din_sync;     // Flash data safe to use.

    // Decoded write to the flash port.
    assign wr_rom   = bus_i.wr && bus_i.addr == nmc_off_rom;
    // Bits 30 to 28 are reserved and read zero.
    assign rom_word = {rom_addr16_enable, 3'h0, rd_en, wr_en, rom_addr, rom_data};

    // ==========================================================
    // Flash data in: a pin, so two flops.
    // The strobe is long enough that the
    // second stage is settled when used.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rom_din_meta <= 8'h00;
            rom_din_sync <= 8'h00;
        end else begin
            rom_din_meta <= rom_din_i;
            rom_din_sync <= rom_din_meta;
        end
    end

    // ==========================================================
    // Descriptor pointers come from same-clock DMA logic; sample them.
    // The copy costs one cycle of latency and
    // keeps the read mux fed only from flops.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_desc <= 32'h00000000;
            rx_desc <= 32'h00000000;
        end else begin
            tx_desc <= tx_desc_ptr_i;
            rx_desc <= rx_desc_ptr_i;
        end
    end

    // ==========================================================
    // Burst counter: software setting and consecutive-success count.
    // A count of zero never fires, and a
    // register write restarts from zero.
    // Software write wins over a pulse.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_burst_count <= nmc_burst_reset[nmc_burst_msb:nmc_burst_lsb];
            burst_done     <= 5'h00;
            ev_done        <= 1'b0;
        end else begin
            ev_done <= 1'b0;
            if (bus_i.wr && bus_i.addr == nmc_off_burst) begin
                tx_burst_count <= bus_i.wdata[nmc_burst_msb:nmc_burst_lsb];
                burst_done     <= 5'h00;
            end else if (tx_ok_i && tx_burst_count != 5'h00) begin
                if (burst_done + 5'h01 == tx_burst_count) begin
                    burst_done <= 5'h00;
                    ev_done    <= 1'b1;
                end else begin
                    burst_done <= burst_done + 5'h01;
                end
            end
        end
    end

    // ==========================================================
    // Tick divider; the tick period follows the link speed.
    // One counter serves both rates; a speed
    // change mid-count only stretches a tick.
    // The tick is an enable, not a clock.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt <= 11'h000;
            tick     <= 1'b0;
        end else begin
            tick <= 1'b0;
            if ((speed_100_i && tick_cnt >= 11'(nmc_tick_100_cyc - 1)) ||
                tick_cnt >= 11'(nmc_tick_10_cyc - 1)) begin
                tick_cnt <= 11'h000;
                tick     <= 1'b1;
            end else begin
                tick_cnt <= tick_cnt + 11'h001;
            end
        end
    end

    // ==========================================================
    // Deferral timer. A new transmit disarms it, so only a timer that
    // runs out while the packet still waits raises the interrupt.
    // A load of zero leaves it disarmed.
    // Software writes load it as well.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_timeout_timer <= nmc_burst_reset[nmc_tmo_msb:0];
            timer_armed      <= 1'b0;
            ev_def           <= 1'b0;
        end else begin
            ev_def <= 1'b0;
            if (bus_i.wr && bus_i.addr == nmc_off_burst) begin
                tx_timeout_timer <= bus_i.wdata[nmc_tmo_msb:0];
                timer_armed      <= bus_i.wdata[nmc_tmo_msb:0] != 12'h000;
            end else if (defer_load_i) begin
                tx_timeout_timer <= defer_backoff_i;
                timer_armed      <= defer_backoff_i != 12'h000;
            end else if (tx_start_i) begin
                timer_armed <= 1'b0;
            end else if (tx_deferred_irq_enable_i && timer_armed && tick) begin
                tx_timeout_timer <= tx_timeout_timer - 12'h001;
                if (tx_timeout_timer == 12'h001) begin
                    timer_armed <= 1'b0;
                    ev_def      <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Flash port fields and sequencer. Software must start one access
    // at a time; a second enable while busy is dropped, not held.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rom_addr16_enable <= nmc_rom_reset[nmc_bon_bit];
            rd_en             <= 1'b0;
            wr_en             <= 1'b0;
            rom_addr          <= 18'h00000;
            rom_data          <= 8'h00;
            rom_state         <= nmc_rom_idle;
            rom_cnt           <= 3'h0;
        end else begin
            // Idle takes a command; busy states
            // count strobe cycles, then go idle.
            unique case (rom_state)
                nmc_rom_idle: begin
                    // Fields update even with no enable.
                    if (wr_rom) begin
                        rom_addr16_enable <= bus_i.wdata[nmc_bon_bit];
                        rom_addr          <= bus_i.wdata[nmc_addr_msb:nmc_addr_lsb];
                        rom_data          <= bus_i.wdata[7:0];
                        rom_cnt           <= 3'h0;
                        if (bus_i.wdata[nmc_ren_bit]) begin
                            rd_en     <= 1'b1;
                            rom_state <= nmc_rom_read;
                        end else if (bus_i.wdata[nmc_wen_bit]) begin
                            wr_en     <= 1'b1;
                            rom_state <= nmc_rom_write;
                        end
                    end
                end
                nmc_rom_read: begin
                    rom_cnt <= rom_cnt + 3'h1;
                    // data ready clears enable
                    // Data is taken on the last strobe cycle.
                    if (rom_cnt == 3'(nmc_rom_cycles - 1)) begin
                        rom_data  <= rom_din_sync;
                        rd_en     <= 1'b0;
                        rom_state <= nmc_rom_idle;
                    end
                end
                nmc_rom_write: begin
                    rom_cnt <= rom_cnt + 3'h1;
                    // Data stays driven until the strobe ends.
                    // write done clears enable
                    if (rom_cnt == 3'(nmc_rom_cycles - 1)) begin
                        wr_en     <= 1'b0;
                        rom_state <= nmc_rom_idle;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Flash pins, all registered.
    // Registered pins keep the strobes free
    // of decode glitches.
    // Field bit 17 drives address line 16.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rom_o        <= '{addr: 18'h00000, dout: 8'h00, data_oe: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
            shared_pin_o <= 1'b0;
        end else begin
            rom_o.addr    <= rom_addr;
            rom_o.dout    <= rom_data;
            rom_o.data_oe <= rom_state == nmc_rom_write;
            rom_o.rd_n    <= rom_state != nmc_rom_read;
            rom_o.wr_n    <= !(rom_state == nmc_rom_write && rom_cnt != 3'h0);
            if (four_led_mode_i && rom_addr16_enable) begin
                shared_pin_o <= rom_addr[17];
            end else begin
                shared_pin_o <= fd_col_led_i;
            end
        end
    end

    // ==========================================================
    // Station address low: EEPROM load, software write otherwise.
    // A write outside the stopped receive state is software's fault.
    // An EEPROM load wins over a software
    // write in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sta_low <= 32'h00000000;
        end else begin
            if (eeprom_load_i) begin
                sta_low <= eeprom_sta_low_i;
            end else if (bus_i.wr && bus_i.addr == nmc_off_sta_low) begin
                sta_low <= bus_i.wdata;
            end
        end
    end

    // ==========================================================
    // Interrupt status (write one to clear; a new event wins) and mask.
    // Bit 0: burst count reached.
    // Bit 1: deferral timer ran out.
    // The level output lags status by one
    // cycle, traded for a glitch-free pin.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
            irq_o    <= 1'b0;
        end else begin
            if (bus_i.wr && bus_i.addr == nmc_off_irq_mask) begin
                irq_mask <= bus_i.wdata[1:0];
            end
            if (bus_i.wr && bus_i.addr == nmc_off_irq_stat) begin
                irq_stat <= (irq_stat & ~bus_i.wdata[1:0]) | {ev_def, ev_done};
            end else begin
                irq_stat <= irq_stat | {ev_def, ev_done};
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // ==========================================================
    // Read data, one cycle after the strobe; unmapped reads zero.
    // Burst word: 20:16 count, 11:0 timer.
    // Idle cycles read zero so a stale word
    // is never mistaken for an answer.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 32'h00000000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                nmc_off_tx_desc:  rdata_o <= tx_desc;
                nmc_off_rx_desc:  rdata_o <= rx_desc;
                nmc_off_burst:    rdata_o <= {11'h000, tx_burst_count, 4'h0, tx_timeout_timer};
                nmc_off_rom:      rdata_o <= rom_word;
                nmc_off_sta_low:  rdata_o <= sta_low;
                nmc_off_irq_stat: rdata_o <= {30'h00000000, irq_stat};
                nmc_off_irq_mask: rdata_o <= {30'h00000000, irq_mask};
                default:          rdata_o <= 32'h00000000;
            endcase
        end else begin
            rdata_o <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/nmc_pkg.sv */
// Package for the NIC miscellaneous control and status register bank.
package nmc_pkg;

    // ==========================================================
    // Register offsets (byte addresses).
    localparam logic [7:0] nmc_off_tx_desc  = 8'h94;
    localparam logic [7:0] nmc_off_rx_desc  = 8'h98;
    localparam logic [7:0] nmc_off_burst    = 8'h9C;
    localparam logic [7:0] nmc_off_rom      = 8'hA0;
    localparam logic [7:0] nmc_off_sta_low  = 8'hA4;
    localparam logic [7:0] nmc_off_irq_stat = 8'hC0;
    localparam logic [7:0] nmc_off_irq_mask = 8'hC4;

    // ==========================================================
    // Field positions.
    localparam int nmc_burst_lsb    = 16;
    localparam int nmc_burst_msb    = 20;
    localparam int nmc_tmo_msb      = 11;
    localparam int nmc_bon_bit      = 31;
    localparam int nmc_ren_bit      = 27;
    localparam int nmc_wen_bit      = 26;
    localparam int nmc_addr_lsb     = 8;
    localparam int nmc_addr_msb     = 25;
    localparam int nmc_irq_done_bit = 0;
    localparam int nmc_irq_def_bit  = 1;

    // ==========================================================
    // Reset values.
    localparam logic [31:0] nmc_rom_reset   = 32'h80000000;
    localparam logic [31:0] nmc_burst_reset = 32'h00000000;

    // ==========================================================
    // Timing: timer tick periods in nanoseconds and in clock cycles.
    localparam int nmc_clk_mhz        = 25;
    localparam int nmc_tick_100_ns    = 2560;
    localparam int nmc_tick_10_ns     = 25600;
    localparam int nmc_tick_100_cyc   = nmc_tick_100_ns * nmc_clk_mhz / 1000;
    localparam int nmc_tick_10_cyc    = nmc_tick_10_ns * nmc_clk_mhz / 1000;
    // Clock cycles that the read strobe is held low (the write strobe one fewer); a plain default.
    localparam int nmc_rom_cycles     = 4;

    // ==========================================================
    // Flash port sequencer states.
    typedef enum logic [2:0] {
        nmc_rom_idle  = 3'b001,
        nmc_rom_read  = 3'b010,
        nmc_rom_write = 3'b100
    } nmc_rom_state_type;

    // Register bus request.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } nmc_bus_type;

    // External flash pins.
    typedef struct packed {
        logic [17:0] addr;
        logic [7:0]  dout;
        logic        data_oe;
        logic        rd_n;
        logic        wr_n;
    } nmc_rom_type;

endpackage
